// *** logic/rspc_top.sv ***
// reset combiner, reset stretcher, reset cause flags and sleep power enables
// assumes analog detectors give levels asynchronous to clock; clock runs from the
// oscillator that the stretched reset gates; powerOnLow also resets this block
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rspc_top #(
  parameter int TOUT_LONG = rspc_pkg::TOUT_LONG_CYC,
  parameter int REF_STARTUP = rspc_pkg::REF_STARTUP_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEn,
  input wire logic hclk_unused,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic powerOnLow,
  input wire logic resetPin_n,
  input wire logic wdtExpire,
  input wire logic wdtEnable,
  input wire logic brownoutLow,
  input wire logic [2:0] brownout_level_fuses,
  input wire logic scanResetReg,
  input wire logic debug_enable_fuse,
  input wire logic scan_port_enable_fuse,
  input wire logic [3:0] clock_select_fuses,
  output logic portReset,
  output logic internalReset,
  output logic comparatorEn,
  output logic vrefEn,
  output logic vrefValid,
  output logic brownoutEn,
  output logic wdtRunEn,
  output logic inputBufEn,
  output logic wakeBufEn,
  output logic mainClockEn,
  output logic debugActive,
  output logic [2:0] sleepModeOut
);
  localparam int CW = $clog2(TOUT_LONG + 1) + 1;
  localparam int RW = $clog2(REF_STARTUP + 1) + 1;

  logic [7:0] causeReg;
  logic [7:0] ctrlReg;
  logic brownoutOn;
  logic borSrc;
  logic wdtSrc;
  logic anySource;
  logic pinLowSync;
  logic borSync;
  logic wdtSync;
  logic scanSync;
  logic wdtPrev;
  logic wdtPulse;
  logic wdtPulseQ;
  logic delayHold;
  logic delayDone;
  logic [CW-1:0] toutLimit;
  logic relSync;
  logic [2:0] sleepSel;
  logic sleeping;
  logic ioClockStopped;
  logic [RW-1:0] refCount;
  logic reqValid;
  logic reqWrite;
  logic [31:0] reqAddr;

  // sleep selector: bit 2 lives in the cause register, bits 1:0 in control
  function automatic logic sleep_stops_io(input logic [2:0] sm);
    sleep_stops_io = (sm != rspc_pkg::SM_IDLE);
  endfunction

  assign brownoutOn = (brownout_level_fuses != 3'h7);
  assign brownoutEn = brownoutOn;
  assign borSrc = brownoutOn & brownoutLow;
  assign wdtSrc = wdtEnable & wdtExpire;

  // async assert keeps reset working with the clock stopped
  assign anySource = powerOnLow | ~resetPin_n | borSrc | wdtPulse | scanResetReg;
  assign portReset = anySource;

  // pin stage resets to idle so no false external flag follows reset; relSync covers the hold
  rspc_sync #(.INIT(1'b0)) uPin (.clock(clock), .rst(rst), .din(~resetPin_n), .dout(pinLowSync));
  rspc_sync #(.INIT(1'b0)) uBor (.clock(clock), .rst(rst), .din(borSrc), .dout(borSync));
  rspc_sync #(.INIT(1'b0)) uWdt (.clock(clock), .rst(rst), .din(wdtSrc), .dout(wdtSync));
  rspc_sync #(.INIT(1'b0)) uScan (.clock(clock), .rst(rst), .din(scanResetReg), .dout(scanSync));

  // one-cycle watchdog pulse from a rising expiry
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdtPrev <= 1'b0;
      wdtPulseQ <= 1'b0;
    end else if (clockEn) begin
      wdtPrev <= wdtSync;
      wdtPulseQ <= wdtSync & ~wdtPrev;
    end
  end
  assign wdtPulse = wdtPulseQ;

  // short timeout for the fast clock choices, long one otherwise
  assign toutLimit = (clock_select_fuses[3]) ? CW'(TOUT_LONG) : CW'(rspc_pkg::TOUT_SHORT_CYC);
  // counter held while any source stands; its fall starts the count
  assign delayHold = pinLowSync | borSync | wdtPulseQ | scanSync | ~relSync;

  rspc_delay #(.WIDTH(CW)) uDelay (
    .clock(clock),
    .rst(rst),
    .clockEn(clockEn),
    .hold(delayHold),
    .limit(toutLimit),
    .done(delayDone)
  );

  // power-on source clears this at once; release waits two edges
  rspc_sync #(.INIT(1'b0)) uRel (.clock(clock), .rst(rst | powerOnLow), .din(1'b1), .dout(relSync));

  // every source but the watchdog sets the internal reset at once, even with the clock stopped
  logic resetAsync;
  assign resetAsync = rst | anySource;
  always_ff @(posedge clock or posedge resetAsync) begin
    if (resetAsync) begin
      internalReset <= 1'b1;
    end else if (clockEn) begin
      // hold term covers the cycle before the counter sees a short watchdog pulse
      internalReset <= ~delayDone | delayHold;
    end
  end
  // internalReset goes to the core: it clears I/O registers and restarts at the vector

  // AHB-Lite slave, zero wait states
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reqValid <= 1'b0;
      reqWrite <= 1'b0;
      reqAddr <= 32'h0000_0000;
    end else if (clockEn && hready) begin
      reqValid <= hsel & htrans[1];
      reqWrite <= hwrite;
      reqAddr <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // cause flags: hardware set wins over a software zero in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      causeReg <= rspc_pkg::CAUSE_RST;
    end else if (clockEn) begin
      if (reqValid && reqWrite && reqAddr == rspc_pkg::OFS_CAUSE) begin
        causeReg <= hwdata[7:0] & causeReg | (hwdata[7:0] & {1'b1, 1'b1, 1'b1, 5'h00});
      end
      if (powerOnLow) begin
        causeReg[rspc_pkg::BIT_JTRF:rspc_pkg::BIT_EXTRF] <= 4'h0;
        causeReg[rspc_pkg::BIT_PORF] <= 1'b1;
      end else begin
        if (pinLowSync) causeReg[rspc_pkg::BIT_EXTRF] <= 1'b1;
        if (borSync) causeReg[rspc_pkg::BIT_BORF] <= 1'b1;
        if (wdtPulseQ) causeReg[rspc_pkg::BIT_WDRF] <= 1'b1;
        if (scanSync) causeReg[rspc_pkg::BIT_JTRF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrlReg <= rspc_pkg::CTRL_RST;
    end else if (clockEn) begin
      if (reqValid && reqWrite && reqAddr == rspc_pkg::OFS_CTRL) begin
        ctrlReg <= hwdata[7:0];
      end else if (internalReset) begin
        ctrlReg[rspc_pkg::BIT_SLEEP] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (clockEn && hready) begin
      if (hsel && htrans[1] && !hwrite && haddr == rspc_pkg::OFS_CAUSE) begin
        hrdata <= {24'h000000, causeReg};
      end else if (hsel && htrans[1] && !hwrite && haddr == rspc_pkg::OFS_CTRL) begin
        hrdata <= {24'h000000, ctrlReg};
      end else if (hsel && htrans[1] && !hwrite && haddr == rspc_pkg::OFS_STATUS) begin
        hrdata <= {22'h0, vrefValid, debugActive, sleepSel, sleeping, internalReset, delayDone, portReset, brownoutOn};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // sleep power enables
  assign sleepSel = {causeReg[rspc_pkg::BIT_SM2], ctrlReg[rspc_pkg::POS_SM+1:rspc_pkg::POS_SM]};
  assign sleepModeOut = sleepSel;
  assign sleeping = ctrlReg[rspc_pkg::BIT_SLEEP];
  assign ioClockStopped = sleeping & sleep_stops_io(sleepSel);
  assign comparatorEn = ~ctrlReg[rspc_pkg::BIT_ACD] & ~ioClockStopped;
  assign vrefEn = brownoutOn | (comparatorEn & ctrlReg[rspc_pkg::BIT_ACBG]);
  assign wdtRunEn = wdtEnable;
  assign inputBufEn = ~ioClockStopped;
  assign wakeBufEn = 1'b1;
  assign debugActive = debug_enable_fuse & scan_port_enable_fuse & ~causeReg[rspc_pkg::BIT_SCANDIS];
  assign mainClockEn = ~sleeping | debugActive | (sleepSel == rspc_pkg::SM_STBY) | (sleepSel == rspc_pkg::SM_XSTBY)
    | (sleepSel == rspc_pkg::SM_IDLE);

  // reference start-up timer; stays valid across sleep while kept on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      refCount <= '0;
    end else if (clockEn) begin
      if (!vrefEn) begin
        refCount <= '0;
      end else if (refCount < RW'(REF_STARTUP)) begin
        refCount <= refCount + 1'b1;
      end
    end
  end
  assign vrefValid = vrefEn & (refCount >= RW'(REF_STARTUP));

  a_wdt_pulse_one: assert property (@(posedge clock) disable iff (rst)
    clockEn && wdtPulseQ |=> !wdtPulseQ) else $error("watchdog pulse longer than one cycle");
  a_port_follows_src: assert property (@(posedge clock) disable iff (rst)
    anySource |-> portReset) else $error("port reset missed a source");
  a_src_holds_reset: assert property (@(posedge clock) disable iff (rst)
    anySource |=> internalReset) else $error("internal reset not asserted");
  a_no_early_release: assert property (@(posedge clock) disable iff (rst)
    $fell(internalReset) |-> $past(delayDone)) else $error("release before timeout");
  a_scan_holds: assert property (@(posedge clock) disable iff (rst)
    scanSync |=> internalReset) else $error("scan reset not held");
  a_comp_sleep_off: assert property (@(posedge clock) disable iff (rst)
    sleeping && sleepSel != rspc_pkg::SM_IDLE |-> !comparatorEn) else $error("comparator on in deep sleep");
  a_vref_need: assert property (@(posedge clock) disable iff (rst)
    vrefEn == (brownoutOn || (comparatorEn && ctrlReg[rspc_pkg::BIT_ACBG]))) else $error("reference enable wrong");
  a_debug_clock: assert property (@(posedge clock) disable iff (rst)
    debugActive |-> mainClockEn) else $error("main clock stopped with debug on");
  a_por_flag: assert property (@(posedge clock) disable iff (rst)
    clockEn && powerOnLow |=> causeReg[rspc_pkg::BIT_PORF] && !causeReg[rspc_pkg::BIT_WDRF]) else $error("power-on flags");
  a_vref_wait: assert property (@(posedge clock) disable iff (rst)
    $rose(vrefEn) |-> !vrefValid) else $error("reference valid too early");
endmodule // rspc_top
`default_nettype wire

// *** pkg/rspc_pkg.sv ***
// constants for the reset and sleep power control block
// assumes one 40 MHz system clock and an AHB-Lite master for software access
package rspc_pkg;
  localparam int CLK_MHZ = 40;
  localparam int REF_STARTUP_US = 70;
  localparam int REF_STARTUP_CYC = REF_STARTUP_US * CLK_MHZ;
  localparam int TOUT_SHORT_CYC = 16;
  localparam int TOUT_LONG_CYC = 4096;
  localparam logic [31:0] OFS_CAUSE = 32'h0000_0000;
  localparam logic [31:0] OFS_CTRL = 32'h0000_0004;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
  localparam int BIT_PORF = 0;
  localparam int BIT_EXTRF = 1;
  localparam int BIT_BORF = 2;
  localparam int BIT_WDRF = 3;
  localparam int BIT_JTRF = 4;
  localparam int BIT_SM2 = 5;
  localparam int BIT_SCANDIS = 7;
  localparam int BIT_ACD = 0;
  localparam int BIT_ACBG = 1;
  localparam int BIT_SLEEP = 2;
  localparam int POS_SM = 4;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] SM_IDLE = 3'h0;
  localparam logic [2:0] SM_PDOWN = 3'h2;
  localparam logic [2:0] SM_PSAVE = 3'h3;
  localparam logic [2:0] SM_STBY = 3'h6;
  localparam logic [2:0] SM_XSTBY = 3'h7;
  typedef enum logic [1:0] {RSPC_HOLD, RSPC_COUNT, RSPC_RUN} rspc_state_e;
endpackage

// *** logic/rspc_sync.sv ***
// two-flop synchroniser with asynchronous assert, used for pin and reset release
// assumes the input may change at any time relative to clock
`timescale 1ns/1ps
`default_nettype none
module rspc_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic stage1;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      dout <= INIT;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // rspc_sync
`default_nettype wire

// *** logic/rspc_delay.sv ***
// delay counter that stretches the internal reset
// assumes hold is a level: the count stays cleared while it is held
`timescale 1ns/1ps
`default_nettype none
module rspc_delay #(
  parameter int WIDTH = 13
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEn,
  input wire logic hold,
  input wire logic [WIDTH-1:0] limit,
  output logic done
);
  logic [WIDTH-1:0] count;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
      done <= 1'b0;
    end else if (clockEn) begin
      if (hold) begin
        count <= '0;
        done <= 1'b0;
      end else if (count >= limit) begin
        done <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule // rspc_delay
`default_nettype wire

// *** verif/rspc_src_model.sv ***
// stand-in for the supply detectors, reset pin, watchdog and scan reset register
// assumes bench requests change just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module rspc_src_model (
  input wire logic clock,
  input wire logic porReq,
  input wire logic pinReq,
  input wire logic wdtReq,
  input wire logic borReq,
  input wire logic scanReq,
  output logic powerOnLow,
  output logic resetPin_n,
  output logic wdtExpire,
  output logic brownoutLow,
  output logic scanResetReg
);
  logic wdtLast;
  // detector levels follow the supply directly, no clock in the path
  assign powerOnLow = porReq;
  assign resetPin_n = ~pinReq;
  assign brownoutLow = borReq;
  assign scanResetReg = scanReq;
  // one expiry per request: the watchdog counter restarts once it has fired
  always_ff @(posedge clock) begin
    wdtLast <= wdtReq;
  end
  assign wdtExpire = wdtReq & ~wdtLast;
endmodule // rspc_src_model
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the reset and sleep power control block
// assumes the source model on the far side and one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 0, rst = 1, clockEn = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic porReq = 1, pinReq = 0, wdtReq = 0, borReq = 0, scanReq = 0;
  logic powerOnLow, resetPin_n, wdtExpire, brownoutLow, scanResetReg;
  logic wdtEnable = 0, dbgFuse = 0, scanFuse = 0;
  logic [2:0] bodFuses = 3'h7, sleepModeOut;
  logic [3:0] clkSel = 4'h0;
  logic portReset, internalReset, comparatorEn, vrefEn, vrefValid, brownoutEn;
  logic wdtRunEn, inputBufEn, wakeBufEn, mainClockEn, debugActive;
  logic [2:0] modes [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
  int miscompares = 0, checkCount = 0, cycles = 0;

  always #12.5 clock = ~clock;

  rspc_src_model i_rspc_src_model (.clock(clock), .porReq(porReq), .pinReq(pinReq), .wdtReq(wdtReq),
    .borReq(borReq), .scanReq(scanReq), .powerOnLow(powerOnLow), .resetPin_n(resetPin_n),
    .wdtExpire(wdtExpire), .brownoutLow(brownoutLow), .scanResetReg(scanResetReg));

  // short counts keep the run brief; expectations below use 16 and 32
  rspc_top #(.TOUT_LONG(32), .REF_STARTUP(20)) i_rspc_top (.clock(clock), .rst(rst), .clockEn(clockEn),
    .hclk_unused(1'b0), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .powerOnLow(powerOnLow), .resetPin_n(resetPin_n), .wdtExpire(wdtExpire), .wdtEnable(wdtEnable),
    .brownoutLow(brownoutLow), .brownout_level_fuses(bodFuses), .scanResetReg(scanResetReg),
    .debug_enable_fuse(dbgFuse), .scan_port_enable_fuse(scanFuse), .clock_select_fuses(clkSel),
    .portReset(portReset), .internalReset(internalReset), .comparatorEn(comparatorEn), .vrefEn(vrefEn),
    .vrefValid(vrefValid), .brownoutEn(brownoutEn), .wdtRunEn(wdtRunEn), .inputBufEn(inputBufEn),
    .wakeBufEn(wakeBufEn), .mainClockEn(mainClockEn), .debugActive(debugActive),
    .sleepModeOut(sleepModeOut));

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles > 8000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // called right after the edge that drops the last source, or that raises the watchdog request
  task automatic holdCount(input int minHold);
    int n;
    n = 0;
    repeat (60) begin
      @(negedge clock);
      if (internalReset === 1'b1) n++;
    end
    check(n >= minHold && n <= minHold + 10, 1);
  endtask

  function automatic logic [2:0] expSleep(input logic [2:0] m, input logic dbg);
    logic deep;
    deep = m != 3'h0;
    return {~deep, ~deep, ~deep | m[2:1] == 2'h3 | dbg};
  endfunction

  initial begin
    logic [2:0] m;
    logic [31:0] r;
    int k;
    void'($urandom(41));
    repeat (3) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    porReq <= 0;
    holdCount(16);
    bus(0, rspc_pkg::OFS_CAUSE, 0);
    check(rd, 32'h1);
    bus(0, 32'h10, 0);
    check(rd, 0);
    check(hresp, 0);
    $display("power-on test done");
    for (k = 0; k < 2; k++) begin
      @(posedge clock);
      clkSel <= k ? 4'h8 : 4'h0;
      clockEn <= 0;
      pinReq <= 1;
      @(negedge clock);
      check(portReset, 1);
      check(internalReset, 1);
      repeat ($urandom_range(6, 2)) @(posedge clock);
      clockEn <= 1;
      repeat (3) @(posedge clock);
      pinReq <= 0;
      holdCount(k ? 32 : 16);
      bus(0, rspc_pkg::OFS_CAUSE, 0);
      check(rd, 32'h3);
    end
    bus(1, rspc_pkg::OFS_CAUSE, 32'h0);
    bus(0, rspc_pkg::OFS_CAUSE, 0);
    check(rd, 32'h0);
    $display("reset pin test done");
    @(posedge clock);
    clkSel <= 4'h0;
    wdtReq <= 1;
    repeat (10) @(posedge clock);
    check(internalReset, 0);
    wdtReq <= 0;
    wdtEnable <= 1;
    @(posedge clock);
    wdtReq <= 1;
    holdCount(16);
    wdtReq <= 0;
    check(wdtRunEn, 1);
    @(posedge clock);
    borReq <= 1;
    repeat (10) @(posedge clock);
    check(internalReset, 0);
    check(brownoutEn, 0);
    bodFuses <= 3'h6;
    repeat (5) @(posedge clock);
    check(internalReset, 1);
    borReq <= 0;
    holdCount(16);
    @(posedge clock);
    scanReq <= 1;
    repeat (40 + $urandom_range(40, 0)) @(posedge clock);
    check(internalReset, 1);
    scanReq <= 0;
    holdCount(16);
    bus(1, rspc_pkg::OFS_CAUSE, 32'h1F);
    bus(0, rspc_pkg::OFS_CAUSE, 0);
    check(rd, 32'h1C);
    @(posedge clock);
    porReq <= 1;
    @(negedge clock);
    check(internalReset, 1);
    @(posedge clock);
    porReq <= 0;
    holdCount(16);
    bus(0, rspc_pkg::OFS_CAUSE, 0);
    check(rd, 32'h1);
    $display("reset source test done");
    for (k = 0; k < 8; k++) begin
      m = modes[k % 5];
      r = $urandom();
      @(posedge clock);
      dbgFuse <= k[0];
      scanFuse <= k[1];
      wdtEnable <= k[1];
      bodFuses <= k[0] ? 3'h6 : 3'h7;
      bus(1, rspc_pkg::OFS_CAUSE, {24'h0, k[2], 1'b0, m[2], 5'h1F});
      bus(1, rspc_pkg::OFS_CTRL, {r[31:8], 2'h0, m[1:0], 4'h4});
      bus(0, rspc_pkg::OFS_CTRL, 0);
      check(rd, {24'h0, 2'h0, m[1:0], 4'h4});
      @(negedge clock);
      check(sleepModeOut, m);
      check(debugActive, k[0] & k[1] & ~k[2]);
      check({comparatorEn, inputBufEn, mainClockEn}, expSleep(m, k[0] & k[1] & ~k[2]));
      check(wakeBufEn, 1);
      check(wdtRunEn, k[1]);
      check(brownoutEn, k[0]);
      check(vrefEn, k[0]);
    end
    bus(1, rspc_pkg::OFS_CTRL, 32'h0);
    bus(1, rspc_pkg::OFS_CAUSE, 32'h1F);
    $display("sleep mode test done");
    @(posedge clock);
    bodFuses <= 3'h7;
    repeat (3) @(posedge clock);
    bus(1, rspc_pkg::OFS_CTRL, 32'h2);
    @(negedge clock);
    check(vrefEn, 1);
    check(vrefValid, 0);
    repeat (25) @(negedge clock);
    check(vrefValid, 1);
    bus(1, rspc_pkg::OFS_CTRL, 32'h6);
    bus(1, rspc_pkg::OFS_CTRL, 32'h2);
    @(negedge clock);
    check(vrefValid, 1);
    bus(1, rspc_pkg::OFS_CTRL, 32'h3);
    @(negedge clock);
    check(vrefEn, 0);
    $display("reference test done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
